// >>> monitor_measurement_sequencer_bench.sv
// Self-checking bench of the measurement sequencer
`timescale 1ns/1ns
`default_nettype none
`include "msq_defs.svh"
module monitor_measurement_sequencer_bench;
   import msq_pkg::*;
   localparam logic [7:0] MC = `MSQ_OFS_MEASURE_CONTROL;
   localparam logic [7:0] CM = `MSQ_OFS_CHANNEL_MODE;
   localparam logic [7:0] CS = `MSQ_OFS_CONVERTER_SETUP;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic ser_busy = 1'b0;
   logic spi_select = 1'b0;
   logic [9:0] base = 10'h000;
   msq_reg_req_t reg_req = '0;
   logic [7:0] reg_rdata;
   logic spi_locked, conv_done, cal_busy, cal_disturbed, int_enable, int_polarity, smbus_timeout_en;
   logic [9:0] conv_data;
   msq_conv_req_t conv_req;
   msq_result_t result;
   logic [14:0] note;
   logic [14:0] exp_q[$];
   int failures = 0;
   int n_compared = 0;
   int n_res = 0;
   int n_done = 0;
   int cycles = 0;
   int done_at_res = 0;
   int mark;

   ////////////////////////////////////////
   // Design and converter model
   msq_sequencer #(.CAL_CYCLES(20)) dut (.sys_clk(sys_clk), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .ser_busy(ser_busy), .spi_select(spi_select), .spi_locked(spi_locked), .conv_req(conv_req),
      .conv_done(conv_done), .conv_data(conv_data), .result(result), .cal_busy(cal_busy),
      .cal_disturbed(cal_disturbed), .int_enable(int_enable), .int_polarity(int_polarity),
      .smbus_timeout_en(smbus_timeout_en));
   msq_conv_model conv (.sys_clk(sys_clk), .nrst(nrst), .conv_req(conv_req), .base(base),
      .conv_done(conv_done), .conv_data(conv_data));

   // Clock
   always #20 sys_clk = ~sys_clk;

   ////////////////////////////////////////
   // Compare, verdict and bus tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
      n_compared++;
      if (seen !== expv)
      begin
         failures++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, expv);
      end
   endtask

   task automatic end_of_test();
      $display("Compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_req <= '{1'b1, a, d};
      @(posedge sys_clk);
      reg_req.wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_req <= '{1'b0, a, 8'h00};
      @(posedge sys_clk);
      #1 chk(reg_rdata, e);
   endtask

   // Notes one round robin pass
   task automatic push_round(input logic ext);
      for (int i = 0; i < 9; i++)
      begin
         exp_q.push_back({1'b0, ((i == 2 && !ext) ? `MSQ_CH_ANALOG_INPUT_ONE : 4'(i)), 10'h000});
         if (i == 2 && !ext)
            exp_q.push_back({1'b0, `MSQ_CH_ANALOG_INPUT_TWO, 10'h000});
      end
   endtask

   task automatic wait_res(input int n);
      int target;
      target = n_res + n;
      for (int i = 0; i < 5000 && n_res < target; i++)
         @(posedge sys_clk);
      chk(n_res >= target, 1'b1);
   endtask

   // Start, optionally disturb, stop and check that it stays stopped
   task automatic run_stop(input logic [7:0] cfg, input int n, input int per);
      int r0;
      int d0;
      r0 = n_res;
      d0 = n_done;
      wr(MC, cfg);
      wait_res(n);
      if (per == 0)
      begin
         for (int i = 0; i < 200 && conv_req.start !== 1'b1; i++)
            @(posedge sys_clk);
         ser_busy <= 1'b1;
         mark = 0;
         repeat (3)
         begin
            @(posedge sys_clk);
            if (conv_req.abort === 1'b1)
               mark = 1;
         end
         ser_busy <= 1'b0;
         chk(mark, 1);
         wait_res(2);
      end
      wr(MC, 8'h00);
      repeat (400) @(posedge sys_clk);
      mark = n_res;
      repeat (300) @(posedge sys_clk);
      chk(n_res, mark);
      if (per > 0)
         chk(done_at_res - d0, (n_res - r0) * per);
      exp_q.delete();
   endtask

   ////////////////////////////////////////
   // Result checker and hang limit
   always @(posedge sys_clk)
   begin
      cycles++;
      if (conv_done === 1'b1)
         n_done++;
      if (result.valid === 1'b1)
      begin
         n_res++;
         done_at_res = n_done;
         note = (exp_q.size() > 0) ? exp_q.pop_front() : 15'h7FFF;
         chk(result.chan, note[13:10]);
         chk(conv_req.chan, note[13:10]);
         if (note[14] === 1'b1)
            chk(result.data, note[9:0]);
      end
      if (cycles == 20000)
      begin
         failures++;
         end_of_test();
      end
   end

   // Main sequence
   initial
   begin
      void'($urandom(32'h284a));
      repeat (5) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      #1 chk({cal_busy, spi_locked, conv_req.fast}, 3'b100);
      for (int i = 0; i < 4; i++)
         rd(MC + 8'(i), 8'h00);
      repeat (30) @(posedge sys_clk);
      #1 chk({cal_busy, cal_disturbed}, 2'b00);
      wr(MC, 8'h60);
      rd(MC, 8'h60);
      #1 chk({int_enable, int_polarity}, 2'b11);
      // Fast clock, supply reference, timeout, no averaging
      wr(CS, 8'h51);
      wr(CM, 8'h20);
      rd(CS, 8'h51);
      rd(CM, 8'h20);
      #1 chk({conv_req.fast, conv_req.ref_vdd, conv_req.filter_off, smbus_timeout_en}, 4'hF);
      // Round robin with the diode, then with the pins as analog inputs
      for (int k = 0; k < 2; k++)
      begin
         push_round(k == 0);
         push_round(k == 0);
         run_stop(k ? 8'h07 : 8'h61, 12, 1);
      end
      // Single channel with averaging and a serial burst
      base <= 10'($urandom_range(1000));
      wr(CM, 8'h15);
      for (int i = 0; i < 8; i++)
         exp_q.push_back({1'b1, 4'h5, base + 10'h001});
      run_stop(8'h01, 2, 16);
      for (int i = 0; i < 8; i++)
         exp_q.push_back({1'b1, 4'h5, base + 10'h001});
      run_stop(8'h01, 1, 0);
      // Port lock survives a software reset
      spi_select <= 1'b1;
      @(posedge sys_clk);
      spi_select <= 1'b0;
      wr(CS, 8'h80);
      for (int i = 0; i < 3; i++)
         rd(MC + 8'(i), 8'h00);
      chk(spi_locked, 1'b1);
      // Second reset with serial traffic during calibration
      @(posedge sys_clk);
      nrst <= 1'b0;
      repeat (5) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      ser_busy <= 1'b1;
      repeat (3) @(posedge sys_clk);
      ser_busy <= 1'b0;
      @(posedge sys_clk);
      #1 chk({spi_locked, cal_busy, cal_disturbed}, 3'b001);
      // Host measures the supply first after a disturbed calibration
      wr(CM, 8'h30);
      exp_q.push_back({1'b0, `MSQ_CH_VDD, 10'h000});
      run_stop(8'h01, 1, 1);
      repeat (50) @(posedge sys_clk);
      end_of_test();
   end
endmodule // monitor_measurement_sequencer_bench
`default_nettype wire

// >>> msq_conv_model.sv
// Converter model answering start requests
`timescale 1ns/1ns
`default_nettype none
module msq_conv_model
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Converter link
   input wire msq_pkg::msq_conv_req_t conv_req,
   input wire logic [9:0] base,
   output logic conv_done,
   output logic [9:0] conv_data
);
   import msq_pkg::*;
   int cnt;
   logic alt;
   // One reading per start after a random delay; abort cancels it
   always_ff @(posedge sys_clk)
   begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data; // Data is not held outside a done
      if (!nrst || conv_req.abort)
      begin
         cnt <= 0;
         alt <= 1'b0;
         conv_data <= 10'h000;
      end
      else if (conv_req.start)
         cnt <= 1 + $urandom_range(4);
      else if (cnt == 1)
      begin
         cnt <= 0;
         conv_done <= 1'b1;
         conv_data <= base + {8'h00, alt, 1'b0}; // Alternates base and base+2
         alt <= ~alt;
      end
      else if (cnt > 1)
         cnt <= cnt - 1;
   end
endmodule // msq_conv_model
`default_nettype wire

// >>> msq_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef MSQ_DEFS_SVH
`define MSQ_DEFS_SVH

// Register offsets
`define MSQ_OFS_MEASURE_CONTROL 8'h18
`define MSQ_OFS_CHANNEL_MODE 8'h19
`define MSQ_OFS_CONVERTER_SETUP 8'h1A

// Reset values: averaging on, slow clock, internal reference, idle
`define MSQ_RST_MEASURE_CONTROL 8'h00
`define MSQ_RST_CHANNEL_MODE 8'h00
`define MSQ_RST_CONVERTER_SETUP 8'h00

// measure_control fields
`define MSQ_MC_START 0
`define MSQ_MC_PIN_LO 1
`define MSQ_MC_PIN_HI 2
`define MSQ_MC_INT_EN 5
`define MSQ_MC_INT_POL 6

// channel_mode_control fields
`define MSQ_CM_CHAN_HI 3
`define MSQ_CM_SINGLE 4
`define MSQ_CM_AVG_OFF 5

// converter_setup fields
`define MSQ_CS_FAST 0
`define MSQ_CS_REF_VDD 4
`define MSQ_CS_SMB_TMO 6
`define MSQ_CS_SW_RESET 7

// Channel codes handed to the converter
`define MSQ_CH_VDD 4'h0
`define MSQ_CH_INT_TEMP 4'h1
`define MSQ_CH_EXT_TEMP 4'h2
`define MSQ_CH_ANALOG_INPUT_THREE 4'h3
`define MSQ_CH_ANALOG_INPUT_EIGHT 4'h8
`define MSQ_CH_ANALOG_INPUT_ONE 4'h9
`define MSQ_CH_ANALOG_INPUT_TWO 4'hA

// Averaging depth
`define MSQ_AVG_LAST 4'hF

// Calibration interval: time in ms, clock in kHz, count derived
`define MSQ_CAL_TIME_MS 5
`define MSQ_CLK_KHZ 25000
`define MSQ_CAL_CYCLES (`MSQ_CAL_TIME_MS * `MSQ_CLK_KHZ)

`endif

// >>> msq_pkg.sv
// Types shared by the measurement sequencer
package msq_pkg;

   // Sequencer states, one-hot
   typedef enum logic [3:0] {
      MSQ_CAL = 4'h1,
      MSQ_IDLE = 4'h2,
      MSQ_ISSUE = 4'h4,
      MSQ_WAIT = 4'h8
   } msq_state_t;

   // Request to the converter
   typedef struct packed {
      logic start;
      logic abort;
      logic [3:0] chan;
      logic fast;
      logic ref_vdd;
      logic filter_off;
   } msq_conv_req_t;

   // Averaged result
   typedef struct packed {
      logic valid;
      logic [3:0] chan;
      logic [9:0] data;
   } msq_result_t;

   // Host register access from the serial engine
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } msq_reg_req_t;

endpackage

// >>> msq_sequencer.sv
// Measurement sequencer of the monitoring converter
`timescale 1ns/1ns
`default_nettype none
`include "msq_defs.svh"

module msq_sequencer #(
   parameter int CAL_CYCLES = `MSQ_CAL_CYCLES
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Register access from the serial engine
   input wire msq_pkg::msq_reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   // Serial engine status
   input wire logic ser_busy,
   input wire logic spi_select,
   output logic spi_locked,
   // Converter
   output msq_pkg::msq_conv_req_t conv_req,
   input wire logic conv_done,
   input wire logic [9:0] conv_data,
   // Results and configuration
   output msq_pkg::msq_result_t result,
   output logic cal_busy,
   output logic cal_disturbed,
   output logic int_enable,
   output logic int_polarity,
   output logic smbus_timeout_en
);
   import msq_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Registers

   logic [7:0] measure_control;
   logic [7:0] channel_mode_control;
   logic [7:0] converter_setup;
   logic sw_reset;
   msq_state_t state;
   msq_state_t next_state;
   logic [31:0] cal_cnt;
   logic [3:0] slot;
   logic [3:0] next_slot;
   logic [3:0] avg_cnt;
   logic [13:0] acc;
   logic avg_on;
   logic ext_diode;
   logic running;
   logic last_read;

   assign avg_on = !channel_mode_control[`MSQ_CM_AVG_OFF];
   assign ext_diode = (measure_control[`MSQ_MC_PIN_HI:`MSQ_MC_PIN_LO] == 2'h0);
   assign running = measure_control[`MSQ_MC_START];
   assign last_read = !avg_on || (avg_cnt == `MSQ_AVG_LAST);
   assign sw_reset = reg_req.wr && (reg_req.addr == `MSQ_OFS_CONVERTER_SETUP)
      && reg_req.wdata[`MSQ_CS_SW_RESET];

   // Host writes; a software reset restores defaults
   always_ff @(posedge sys_clk)
   begin
      if (!nrst || sw_reset)
      begin
         measure_control <= `MSQ_RST_MEASURE_CONTROL;
         channel_mode_control <= `MSQ_RST_CHANNEL_MODE;
         converter_setup <= `MSQ_RST_CONVERTER_SETUP;
      end
      else if (reg_req.wr)
      begin
         case (reg_req.addr)
            `MSQ_OFS_MEASURE_CONTROL: measure_control <= reg_req.wdata;
            `MSQ_OFS_CHANNEL_MODE: channel_mode_control <= reg_req.wdata;
            `MSQ_OFS_CONVERTER_SETUP: converter_setup <= reg_req.wdata;
            default: measure_control <= measure_control;
         endcase
      end
   end

   // Read data, registered; unmapped offsets read zero
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         reg_rdata <= 8'h00;
      else
      begin
         case (reg_req.addr)
            `MSQ_OFS_MEASURE_CONTROL: reg_rdata <= measure_control;
            `MSQ_OFS_CHANNEL_MODE: reg_rdata <= channel_mode_control;
            `MSQ_OFS_CONVERTER_SETUP: reg_rdata <= converter_setup;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   // Configuration outputs toward interrupt and bus logic
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         int_enable <= 1'b0;
         int_polarity <= 1'b0;
         smbus_timeout_en <= 1'b0;
      end
      else
      begin
         int_enable <= measure_control[`MSQ_MC_INT_EN];
         int_polarity <= measure_control[`MSQ_MC_INT_POL];
         smbus_timeout_en <= converter_setup[`MSQ_CS_SMB_TMO];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Serial protocol lock

   // I2C after power up; SPI sticks until nrst is next asserted, a software reset keeps it
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         spi_locked <= 1'b0;
      else if (spi_select)
         spi_locked <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // Calibration

   // Calibration timer; serial traffic cuts it short
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         cal_cnt <= 32'h0;
         cal_disturbed <= 1'b0;
      end
      else if (state == MSQ_CAL)
      begin
         cal_cnt <= cal_cnt + 32'h1;
         if (ser_busy)
            cal_disturbed <= 1'b1;
      end
   end

   assign cal_busy = (state == MSQ_CAL);

   ////////////////////////////////////////////////////////////////////////
   // Channel selection

   // Next channel after a finished result
   always_comb
   begin
      next_slot = slot;
      if (channel_mode_control[`MSQ_CM_SINGLE])
         next_slot = channel_mode_control[`MSQ_CM_CHAN_HI:0];
      else
      begin
         case (slot)
            `MSQ_CH_VDD: next_slot = `MSQ_CH_INT_TEMP;
            `MSQ_CH_INT_TEMP: next_slot = ext_diode ? `MSQ_CH_EXT_TEMP : `MSQ_CH_ANALOG_INPUT_ONE;
            `MSQ_CH_ANALOG_INPUT_ONE: next_slot = `MSQ_CH_ANALOG_INPUT_TWO;
            `MSQ_CH_EXT_TEMP, `MSQ_CH_ANALOG_INPUT_TWO: next_slot = `MSQ_CH_ANALOG_INPUT_THREE;
            `MSQ_CH_ANALOG_INPUT_EIGHT: next_slot = `MSQ_CH_VDD;
            default: next_slot = slot + 4'h1;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer

   // State transitions
   always_comb
   begin
      next_state = state;
      case (state)
         MSQ_CAL:
            if (ser_busy || cal_cnt >= CAL_CYCLES - 1)
               next_state = MSQ_IDLE;
         MSQ_IDLE:
            if (running && !ser_busy)
               next_state = MSQ_ISSUE;
         MSQ_ISSUE:
            if (!running)
               next_state = MSQ_IDLE;
            else if (!ser_busy)
               next_state = MSQ_WAIT;
         MSQ_WAIT:
            if (!running)
               next_state = MSQ_IDLE;
            else if (ser_busy || conv_done)
               next_state = MSQ_ISSUE;
         default:
            next_state = MSQ_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         state <= MSQ_CAL;
      else
         state <= next_state;
   end

   // Channel pointer; a fresh start or a mode switch takes effect here
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         slot <= `MSQ_CH_VDD;
      else if (state == MSQ_IDLE)
         slot <= channel_mode_control[`MSQ_CM_SINGLE] ?
            channel_mode_control[`MSQ_CM_CHAN_HI:0] : `MSQ_CH_VDD;
      else if (state == MSQ_WAIT && conv_done && !ser_busy && last_read)
         slot <= next_slot;
   end

   // Averaging accumulator; aborts discard partial sums
   always_ff @(posedge sys_clk)
   begin
      if (!nrst || state != MSQ_WAIT && state != MSQ_ISSUE)
      begin
         acc <= 14'h0;
         avg_cnt <= 4'h0;
      end
      else if (state == MSQ_WAIT && ser_busy)
      begin
         acc <= 14'h0;
         avg_cnt <= 4'h0;
      end
      else if (state == MSQ_WAIT && conv_done)
      begin
         acc <= last_read ? 14'h0 : acc + {4'h0, conv_data};
         avg_cnt <= last_read ? 4'h0 : avg_cnt + 4'h1;
      end
   end

   // Result register, written only when the average is complete
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         result <= '0;
      else
      begin
         result.valid <= 1'b0;
         if (state == MSQ_WAIT && conv_done && !ser_busy && last_read)
         begin
            result.valid <= 1'b1;
            result.chan <= slot;
            if (avg_on)
               result.data <= 10'((acc + {4'h0, conv_data}) >> 4);
            else
               result.data <= conv_data;
         end
      end
   end

   // Converter request
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         conv_req <= '0;
      else
      begin
         conv_req.start <= (state == MSQ_ISSUE) && running && !ser_busy;
         conv_req.abort <= (state == MSQ_WAIT) && ser_busy;
         conv_req.chan <= slot;
         conv_req.fast <= converter_setup[`MSQ_CS_FAST];
         conv_req.filter_off <= converter_setup[`MSQ_CS_FAST];
         conv_req.ref_vdd <= converter_setup[`MSQ_CS_REF_VDD];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   sequence s_done_last;
      state == MSQ_WAIT && conv_done && !ser_busy && last_read && running;
   endsequence

   sequence s_result_out;
      result.valid;
   endsequence

   chk_idle_after_cal: assert property (@(posedge sys_clk) disable iff (!nrst)
      state == MSQ_CAL && ser_busy |=> state == MSQ_IDLE && !conv_req.start)
      else $error("calibration did not end in idle");

   chk_start_runs: assert property (@(posedge sys_clk) disable iff (!nrst)
      state == MSQ_IDLE && running && !ser_busy |=> state == MSQ_ISSUE ##1 conv_req.start)
      else $error("start bit did not begin measuring");

   chk_stop_idle: assert property (@(posedge sys_clk) disable iff (!nrst)
      !running && state != MSQ_CAL |=> state == MSQ_IDLE)
      else $error("clearing start did not stop");

   chk_wrap_supply: assert property (@(posedge sys_clk) disable iff (!nrst)
      s_done_last and slot == `MSQ_CH_ANALOG_INPUT_EIGHT && !channel_mode_control[`MSQ_CM_SINGLE]
      |=> slot == `MSQ_CH_VDD)
      else $error("sequence did not wrap to supply");

   chk_no_diode_slot: assert property (@(posedge sys_clk) disable iff (!nrst)
      s_done_last and slot == `MSQ_CH_INT_TEMP && !ext_diode
      && !channel_mode_control[`MSQ_CM_SINGLE] |=> slot == `MSQ_CH_ANALOG_INPUT_ONE)
      else $error("analog pair not measured in slot three");

   chk_avg_result: assert property (@(posedge sys_clk) disable iff (!nrst)
      s_result_out |-> $past(avg_cnt) == `MSQ_AVG_LAST || !$past(avg_on))
      else $error("result published before full average");

   chk_abort_conv: assert property (@(posedge sys_clk) disable iff (!nrst)
      state == MSQ_WAIT && ser_busy && running |=> conv_req.abort && !result.valid)
      else $error("serial activity did not abort conversion");

   chk_spi_lock: assert property (@(posedge sys_clk) disable iff (!nrst)
      spi_locked |=> spi_locked)
      else $error("SPI lock released");

   chk_fast_filter: assert property (@(posedge sys_clk) disable iff (!nrst)
      conv_req.fast == conv_req.filter_off)
      else $error("diode filters not tied to fast clock");

endmodule // msq_sequencer
`default_nettype wire
